// file: hw/ucb_pkg.sv
package ucb_pkg;

    // Register offsets on the plain register port.
    localparam int         ADDR_W    = 3;
    localparam logic [2:0] OFS_CTRL1 = 3'h0;
    localparam logic [2:0] OFS_CTRL2 = 3'h1;
    localparam logic [2:0] OFS_DATA  = 3'h2;
    localparam logic [2:0] OFS_DIV   = 3'h3;
    localparam logic [2:0] OFS_STAT  = 3'h4;
    localparam logic [2:0] OFS_ISTAT = 3'h5;
    localparam logic [2:0] OFS_IMASK = 3'h6;

    // Field positions of the first control register.
    localparam int         C1_UNIT  = 7;
    localparam int         C1_NINE  = 6;
    localparam int         C1_BRK   = 2;
    localparam int         C1_RX9   = 1;
    localparam int         C1_TX9   = 0;
    localparam logic [7:0] C1_WMASK = 8'hc5;

    // Field positions of the line status register.
    localparam int ST_OVR    = 5;
    localparam int ST_RXIDLE = 3;
    localparam int ST_RDY    = 2;
    localparam int ST_TX_IDLE_FLAG  = 1;
    localparam int ST_TEMPTY = 0;

    // Interrupt status and mask layout.
    localparam int IRQ_W      = 3;
    localparam int IRQ_RX     = 0;
    localparam int IRQ_TX_IDLE_FLAG  = 1;
    localparam int IRQ_TEMPTY = 2;

    // Reset values.
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] DIV_RST   = 8'h00;

    // Prescaler lengths, frame lengths and break length in bit times.
    localparam logic [6:0] PRE_LOW    = 7'h40;
    localparam logic [6:0] PRE_HIGH   = 7'h10;
    localparam logic [3:0] FRAME8     = 4'ha;
    localparam logic [3:0] FRAME9     = 4'hb;
    localparam logic [3:0] BREAK_BITS = 4'hd;
    localparam logic [3:0] LAST8      = 4'h7;
    localparam logic [3:0] LAST9      = 4'h8;

    typedef struct packed {
        logic transmitter_enable;
        logic receiver_enable;
        logic baud_high_speed;
        logic address_detect_enable;
        logic wake_enable;
        logic receive_int_enable;
        logic tx_idle_int_enable;
        logic tx_empty_int_enable;
    } ucb_ctrl2_s;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} ucb_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucb_rx_e;

endpackage

// file: hw/ucb_uart_ctrl.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// R1 - Transmitter enable low aborts and resets transmitter.
// R2 - Transmitter drives pin only when both enabled.
// R3 - Receiver enable low aborts and resets receiver.
// R4 - Receiver owns pin only when both enabled.
// R5 - Baud is clock over 64 or 16 times N+1.
// R6 - Free running eight bit divisor timer, N any.
// R7 - Address bit one marks word, may interrupt.
// R8 - Address bit zero word discarded without interrupt.
// R9 - Wake enable set wakes on falling receive edge.
// R10 - Wake enable clear never wakes the device.
// R11 - Receive enable routes overrun or ready to request.
// R12 - Idle enable routes transmitter idle to request.
// R13 - Empty enable routes buffer empty to request.
// R14 - One data location: write sends, read receives.
// R15 - Unit disable flushes, clears transmit and receive enables, sets idle flags.
// R16 - Idle flag when empty and nothing being sent.
// R17 - Ready flag set when word reaches data register.
// R18 - Request is OR of enabled sources.
// R19 - Counter reloads divisor; prescaler gives bit period.
module ucb_uart_ctrl
    import ucb_pkg::*;
#(
    parameter int DIV_W = 8
)(
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire logic              rx_i,
    input  wire logic              low_power_idle_i,
    output logic                   tx_o,
    output logic                   tx_oe_o,
    output logic                   rx_owned_o,
    output logic                   wake_o,
    output logic                   irq_o
);

    logic [7:0]       ctrl1, next_ctrl1;
    ucb_ctrl2_s       ctrl2, next_ctrl2;
    logic [DIV_W-1:0] divisor, next_divisor;
    logic [IRQ_W-1:0] irq_st, next_irq_st;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [IRQ_W-1:0] flag_q, flags, events;
    logic [7:0]       next_rdata;
    logic             next_irq, next_wake;
    logic [DIV_W-1:0] brg_cnt, next_brg_cnt;
    logic             tick, next_tick;
    ucb_tx_e          tx_st, next_tx_st;
    logic [10:0]      tx_sh, next_tx_sh;
    logic [3:0]       tx_bits, next_tx_bits;
    logic [6:0]       tx_ph, next_tx_ph;
    logic             tx_full, next_tx_full;
    logic [7:0]       tx_buf, next_tx_buf;
    logic             next_tx_pin;
    logic [2:0]       rx_s;
    logic             rx_lvl, next_rx_lvl, rx_fall;
    ucb_rx_e          rx_st, next_rx_st;
    logic [8:0]       rx_sh, next_rx_sh;
    logic [3:0]       rx_bits, next_rx_bits;
    logic [6:0]       rx_ph, next_rx_ph;
    logic             rx_ready, next_rx_ready;
    logic             rx_ovr, next_rx_ovr;
    logic [7:0]       rx_buf, next_rx_buf;
    logic             rx9, next_rx9;
    logic             unit, nine, tx_run, rx_run;
    logic             tx_empty, tx_idle;
    logic [6:0]       pre_cnt, pre_last, half_last;
    logic             wr_data, rd_data;

    // Shared decode of enables, prescaler length and data port access.
    assign unit      = ctrl1[C1_UNIT];
    assign nine      = ctrl1[C1_NINE];
    // R2 both enables
    assign tx_run    = unit & ctrl2.transmitter_enable;
    // R4 both enables
    assign rx_run    = unit & ctrl2.receiver_enable;
    // R5 prescale select
    assign pre_cnt   = ctrl2.baud_high_speed ? PRE_HIGH : PRE_LOW;
    assign pre_last  = pre_cnt - 7'h01;
    assign half_last = (pre_cnt >> 1) - 7'h01;
    // R14 shared data location
    assign wr_data   = wr_i && (addr_i == OFS_DATA);
    assign rd_data   = rd_i && (addr_i == OFS_DATA);
    assign tx_empty  = ~tx_full;
    // R16 idle flag
    assign tx_idle   = tx_empty & (tx_st == TX_IDLE) & ~ctrl1[C1_BRK];

    // Divisor timer runs freely; one tick every N+1 clocks.
    always_comb
    begin
        next_brg_cnt = brg_cnt;
        next_tick    = 1'b0;
        // R15 counter reset
        if (!unit)
            next_brg_cnt = '0;
        // R6 R19 reload and tick
        else if (brg_cnt == '0)
        begin
            next_brg_cnt = divisor;
            next_tick    = 1'b1;
        end
        else
        begin
            next_brg_cnt = brg_cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            brg_cnt <= '0;
            tick    <= 1'b0;
        end
        else
        begin
            brg_cnt <= next_brg_cnt;
            tick    <= next_tick;
        end
    end

    // Transmitter: holding buffer, shift register and break generator.
    always_comb
    begin
        next_tx_st   = tx_st;
        next_tx_sh   = tx_sh;
        next_tx_bits = tx_bits;
        next_tx_ph   = tx_ph;
        next_tx_full = tx_full;
        next_tx_buf  = tx_buf;
        // R1 R15 abort and flush
        if (!tx_run)
        begin
            next_tx_st   = TX_IDLE;
            next_tx_sh   = '1;
            next_tx_bits = '0;
            next_tx_ph   = '0;
            next_tx_full = 1'b0;
        end
        else
        begin
            // A write while the buffer is full is dropped, not queued.
            if (wr_data && !tx_full)
            begin
                next_tx_buf  = wdata_i;
                next_tx_full = 1'b1;
            end
            unique case (tx_st)
                TX_IDLE:
                begin
                    if (tx_full)
                    begin
                        next_tx_sh   = {1'b1, nine ? ctrl1[C1_TX9] : 1'b1,
                                        tx_buf, 1'b0};
                        next_tx_bits = nine ? FRAME9 : FRAME8;
                        next_tx_ph   = '0;
                        next_tx_full = 1'b0;
                        next_tx_st   = TX_SHIFT;
                    end
                    else if (ctrl1[C1_BRK])
                    begin
                        next_tx_bits = BREAK_BITS;
                        next_tx_ph   = '0;
                        next_tx_st   = TX_BREAK;
                    end
                end
                TX_SHIFT:
                begin
                    // R19 bit period
                    if (tick && tx_ph == pre_last)
                    begin
                        next_tx_ph   = '0;
                        next_tx_sh   = {1'b1, tx_sh[10:1]};
                        next_tx_bits = tx_bits - 1'b1;
                        if (tx_bits == 4'h1)
                            next_tx_st = TX_IDLE;
                    end
                    else if (tick)
                    begin
                        next_tx_ph = tx_ph + 7'h01;
                    end
                end
                TX_BREAK:
                begin
                    // Break lasts at least its minimum and until released.
                    if (tick && tx_ph == pre_last)
                    begin
                        next_tx_ph = '0;
                        if (tx_bits != 4'h0)
                            next_tx_bits = tx_bits - 1'b1;
                    end
                    else if (tick)
                    begin
                        next_tx_ph = tx_ph + 7'h01;
                    end
                    if (tx_bits == 4'h0 && !ctrl1[C1_BRK])
                        next_tx_st = TX_IDLE;
                end
            endcase
        end
        next_tx_pin = (next_tx_st != TX_BREAK) & next_tx_sh[0];
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_st   <= TX_IDLE;
            tx_sh   <= '1;
            tx_bits <= '0;
            tx_ph   <= '0;
            tx_full <= 1'b0;
            tx_buf  <= 8'h00;
            tx_o    <= 1'b1;
            tx_oe_o <= 1'b0;
        end
        else
        begin
            tx_st   <= next_tx_st;
            tx_sh   <= next_tx_sh;
            tx_bits <= next_tx_bits;
            tx_ph   <= next_tx_ph;
            tx_full <= next_tx_full;
            tx_buf  <= next_tx_buf;
            tx_o    <= next_tx_pin;
            tx_oe_o <= tx_run;
        end
    end

    // Receiver: pin filter, mid-bit sampling and word delivery.
    always_comb
    begin
        next_rx_lvl   = (rx_s[1] == rx_s[2]) ? rx_s[2] : rx_lvl;
        rx_fall       = rx_lvl & ~next_rx_lvl;
        next_rx_st    = rx_st;
        next_rx_sh    = rx_sh;
        next_rx_bits  = rx_bits;
        next_rx_ph    = rx_ph;
        next_rx_ready = rx_ready;
        next_rx_ovr   = rx_ovr;
        next_rx_buf   = rx_buf;
        next_rx9      = rx9;
        // R3 R15 abort and flush
        if (!rx_run)
        begin
            next_rx_st    = RX_IDLE;
            next_rx_bits  = '0;
            next_rx_ph    = '0;
            next_rx_ready = 1'b0;
            next_rx_ovr   = 1'b0;
        end
        else
        begin
            // Reading the data location consumes the word first.
            if (rd_data)
            begin
                next_rx_ready = 1'b0;
                next_rx_ovr   = 1'b0;
            end
            unique case (rx_st)
                RX_IDLE:
                begin
                    if (rx_fall)
                    begin
                        next_rx_ph = '0;
                        next_rx_st = RX_START;
                    end
                end
                RX_START:
                begin
                    // A start bit gone high by mid-bit was a glitch.
                    if (tick && rx_ph == half_last)
                    begin
                        next_rx_ph   = '0;
                        next_rx_bits = '0;
                        next_rx_st   = rx_lvl ? RX_IDLE : RX_DATA;
                    end
                    else if (tick)
                    begin
                        next_rx_ph = rx_ph + 7'h01;
                    end
                end
                RX_DATA:
                begin
                    if (tick && rx_ph == pre_last)
                    begin
                        next_rx_ph   = '0;
                        next_rx_sh   = {rx_lvl, rx_sh[8:1]};
                        next_rx_bits = rx_bits + 1'b1;
                        if (rx_bits == (nine ? LAST9 : LAST8))
                            next_rx_st = RX_STOP;
                    end
                    else if (tick)
                    begin
                        next_rx_ph = rx_ph + 7'h01;
                    end
                end
                RX_STOP:
                begin
                    if (tick && rx_ph == pre_last)
                    begin
                        next_rx_ph = '0;
                        next_rx_st = RX_IDLE;
                        // R7 R8 top bit is the address bit either way
                        if (!ctrl2.address_detect_enable || rx_sh[8])
                        begin
                            // R11 overrun keeps the older word
                            if (next_rx_ready)
                            begin
                                next_rx_ovr = 1'b1;
                            end
                            // R17 word to data register
                            else
                            begin
                                next_rx_buf   = nine ? rx_sh[7:0]
                                                     : rx_sh[8:1];
                                next_rx9      = nine ? rx_sh[8] : rx9;
                                next_rx_ready = 1'b1;
                            end
                        end
                    end
                    else if (tick)
                    begin
                        next_rx_ph = rx_ph + 7'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_s       <= 3'h7;
            rx_lvl     <= 1'b1;
            rx_st      <= RX_IDLE;
            rx_sh      <= '0;
            rx_bits    <= '0;
            rx_ph      <= '0;
            rx_ready   <= 1'b0;
            rx_ovr     <= 1'b0;
            rx_buf     <= 8'h00;
            rx9        <= 1'b0;
            rx_owned_o <= 1'b0;
        end
        else
        begin
            rx_s       <= {rx_s[1:0], rx_i};
            rx_lvl     <= next_rx_lvl;
            rx_st      <= next_rx_st;
            rx_sh      <= next_rx_sh;
            rx_bits    <= next_rx_bits;
            rx_ph      <= next_rx_ph;
            rx_ready   <= next_rx_ready;
            rx_ovr     <= next_rx_ovr;
            rx_buf     <= next_rx_buf;
            rx9        <= next_rx9;
            rx_owned_o <= rx_run;
        end
    end

    // Register file, interrupt collection, read port and wake-up.
    always_comb
    begin
        next_ctrl1    = ctrl1;
        next_ctrl2    = ctrl2;
        next_divisor  = divisor;
        next_irq_st   = irq_st;
        next_irq_mask = irq_mask;
        next_rdata    = 8'h00;
        if (wr_i)
        begin
            case (addr_i)
                OFS_CTRL1:
                begin
                    next_ctrl1 = wdata_i & C1_WMASK;
                    // R15 disable clears transmit and receive enables and break
                    if (unit && !wdata_i[C1_UNIT])
                    begin
                        next_ctrl1[C1_BRK]            = 1'b0;
                        next_ctrl2.transmitter_enable = 1'b0;
                        next_ctrl2.receiver_enable    = 1'b0;
                    end
                end
                OFS_CTRL2: next_ctrl2 = wdata_i;
                OFS_DIV:   next_divisor = wdata_i[DIV_W-1:0];
                OFS_ISTAT: next_irq_st = irq_st & ~wdata_i[IRQ_W-1:0];
                OFS_IMASK: next_irq_mask = wdata_i[IRQ_W-1:0];
                default:   ;
            endcase
        end
        // R11 R12 R13 rising flags, gated by enables
        flags[IRQ_RX]     = rx_ready | rx_ovr;
        flags[IRQ_TX_IDLE_FLAG]  = tx_idle;
        flags[IRQ_TEMPTY] = tx_empty;
        events = flags & ~flag_q & {ctrl2.tx_empty_int_enable,
                                    ctrl2.tx_idle_int_enable,
                                    ctrl2.receive_int_enable};
        // A new event beats a clear in the same cycle.
        next_irq_st = next_irq_st | events;
        // R18 one request
        next_irq = |(next_irq_st & next_irq_mask);
        if (rd_i)
        begin
            case (addr_i)
                OFS_CTRL1: next_rdata = {ctrl1[7:2], rx9, 1'b0};
                OFS_CTRL2: next_rdata = ctrl2;
                // R14 read returns received byte
                OFS_DATA:  next_rdata = rx_buf;
                OFS_DIV:   next_rdata = 8'(divisor);
                OFS_STAT:
                begin
                    next_rdata[ST_OVR]    = rx_ovr;
                    next_rdata[ST_RXIDLE] = rx_st == RX_IDLE;
                    next_rdata[ST_RDY]    = rx_ready;
                    next_rdata[ST_TX_IDLE_FLAG]  = tx_idle;
                    next_rdata[ST_TEMPTY] = tx_empty;
                end
                OFS_ISTAT: next_rdata = 8'(irq_st);
                OFS_IMASK: next_rdata = 8'(irq_mask);
                default:   next_rdata = 8'h00;
            endcase
        end
        // R9 R10 wake only when enabled and asleep
        next_wake = ctrl2.wake_enable & low_power_idle_i & rx_fall;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl1    <= CTRL1_RST;
            ctrl2    <= CTRL2_RST;
            divisor  <= DIV_W'(DIV_RST);
            irq_st   <= '0;
            irq_mask <= '0;
            flag_q   <= '1;
            rdata_o  <= 8'h00;
            irq_o    <= 1'b0;
            wake_o   <= 1'b0;
        end
        else
        begin
            ctrl1    <= next_ctrl1;
            ctrl2    <= next_ctrl2;
            divisor  <= next_divisor;
            irq_st   <= next_irq_st;
            irq_mask <= next_irq_mask;
            flag_q   <= flags;
            rdata_o  <= next_rdata;
            irq_o    <= next_irq;
            wake_o   <= next_wake;
        end
    end

endmodule

// file: test/ucb_uart_ctrl_asserts.sv
`timescale 1ns/100ps
module ucb_uart_ctrl_asserts
    import ucb_pkg::*;
#(
    parameter int DIV_W = 8
)(
    input wire logic              core_clk_i,
    input wire logic              rstn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              rx_i,
    input wire logic              low_power_idle_i,
    input wire logic              tx_o,
    input wire logic              tx_oe_o,
    input wire logic              rx_owned_o,
    input wire logic              wake_o,
    input wire logic              irq_o
);
    logic       unit;
    logic       next_unit;
    logic [7:0] c2;
    logic [7:0] next_c2;
    logic [7:0] dv;
    logic [7:0] next_dv;
    logic [2:0] msk;
    logic [2:0] next_msk;
    logic       txon;
    logic       rxon;

    // Shadow of the control writes, so outputs can be tied to a cause.
    always_comb
    begin
        next_unit = unit;
        next_c2   = c2;
        next_dv   = dv;
        next_msk  = msk;
        if (wr_i && addr_i == OFS_CTRL1)
        begin
            next_unit = wdata_i[C1_UNIT];
            if (unit && !wdata_i[C1_UNIT])
                next_c2[7:6] = 2'b00;
        end
        if (wr_i && addr_i == OFS_CTRL2)
            next_c2 = wdata_i;
        if (wr_i && addr_i == OFS_DIV)
            next_dv = wdata_i;
        if (wr_i && addr_i == OFS_IMASK)
            next_msk = wdata_i[2:0];
    end

    // Registered copy, cleared by reset like the block's own registers.
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            unit <= 1'b0;
            c2   <= 8'h00;
            dv   <= 8'h00;
            msk  <= 3'h0;
        end
        else
        begin
            unit <= next_unit;
            c2   <= next_c2;
            dv   <= next_dv;
            msk  <= next_msk;
        end
    end

    assign txon = unit & c2[7];
    assign rxon = unit & c2[6];

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_tx_pin_own: assert property (tx_oe_o == $past(txon))
        else $error("tx pin ownership wrong");
    a_tx_rest_high: assert property (!$past(txon) |-> tx_o)
        else $error("tx line not idle while stopped");
    a_rx_released: assert property (!$past(rxon) |-> !rx_owned_o)
        else $error("rx pin held while off");
    a_rx_owned: assert property (rxon && $past(rxon) |-> rx_owned_o)
        else $error("rx pin not taken");
    a_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_div_read: assert property (rd_i && addr_i == OFS_DIV
        |=> rdata_o == $past(dv))
        else $error("divisor read back wrong");
    a_ctrl_read: assert property (rd_i && addr_i == OFS_CTRL2
        |=> rdata_o == $past(c2))
        else $error("enable register read back wrong");
    a_irq_masked: assert property (msk == 3'h0 |-> !irq_o)
        else $error("irq with all sources masked");
    a_wake_gated: assert property (wake_o |-> c2[3] || $past(c2[3]))
        else $error("wake while wake disabled");
    a_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake longer than a pulse");
endmodule

// file: test/ucb_remote.sv
`timescale 1ns/100ps
module ucb_remote (
    input  wire logic        clk_i,
    input  wire logic        tx_i,
    input  wire logic        tx_oe_i,
    output logic             rx_o,
    input  wire logic [15:0] bit_i
);
    logic [7:0] got;
    int         low_len;

    // The line idles high between frames, as a pulled-up wire would.
    initial rx_o = 1'b1;

    // Frames from the block are sampled mid-bit; the start bit is timed.
    always
    begin
        @(negedge tx_i iff tx_oe_i);
        low_len = 0;
        while (tx_i === 1'b0 && low_len < 2 * bit_i)
        begin
            @(posedge clk_i);
            #1;
            low_len++;
        end
        repeat (bit_i / 2) @(posedge clk_i);
        for (int k = 0; k < 8; k++)
        begin
            got[k] = tx_i;
            repeat (bit_i) @(posedge clk_i);
        end
    end

    // Sends one frame, LSB first, then rests in the stop level.
    task send(input logic [8:0] w, input int nb);
        @(posedge clk_i);
        rx_o <= 1'b0;
        repeat (bit_i) @(posedge clk_i);
        for (int k = 0; k < nb; k++)
        begin
            rx_o <= w[k];
            repeat (bit_i) @(posedge clk_i);
        end
        rx_o <= 1'b1;
        repeat (bit_i + 6) @(posedge clk_i);
    endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
    import ucb_pkg::*;
    typedef struct packed {
        logic        hs;
        logic [7:0]  n;
        logic [7:0]  d;
        logic [15:0] bt;
    } ucb_row_s;
    logic        clk, rstn, wr, rd, rx, lpi, tx, txoe, rxown, wake, irq;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [15:0] bt;
    int          fails, num_checks, cyc, wakes;
    ucb_row_s    rows [3] = '{'{1'b1, 8'h00, 8'h55, 16'h10},
                              '{1'b1, 8'h01, 8'ha3, 16'h20},
                              '{1'b0, 8'h00, 8'h0f, 16'h40}};

    ucb_uart_ctrl #(.DIV_W(8)) DUT (.core_clk_i(clk), .rstn_i(rstn),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rx_i(rx), .low_power_idle_i(lpi), .tx_o(tx),
        .tx_oe_o(txoe), .rx_owned_o(rxown), .wake_o(wake), .irq_o(irq));
    ucb_remote rem (.clk_i(clk), .tx_i(tx), .tx_oe_i(txoe), .rx_o(rx),
        .bit_i(bt));

    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Bus cycles change signals right after an edge, one strobe cycle.
    task wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata & m, e);
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // Cycle count for the hang limit, plus a tally of wake pulses.
    always @(posedge clk)
    begin
        cyc++;
        if (wake === 1'b1)
            wakes++;
        if (cyc == 30000)
        begin
            fails++;
            give_verdict;
        end
    end

    initial
    begin
        {rstn, wr, rd, lpi, addr, wdata} = '0;
        bt = 16'h10;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rchk(OFS_CTRL2, 8'hff, 8'h00);
        wreg(3'h7, 8'hff);
        rchk(3'h7, 8'hff, 8'h00);
        wreg(OFS_CTRL1, 8'h80);
        wreg(OFS_IMASK, 8'h06);
        // Each row: speed, divisor and byte out, then the rate and irqs.
        foreach (rows[i])
        begin
            bt = rows[i].bt;
            wreg(OFS_DIV, rows[i].n);
            rchk(OFS_DIV, 8'hff, rows[i].n);
            wreg(OFS_CTRL2, {2'b10, rows[i].hs, 5'b00011});
            wreg(OFS_DATA, rows[i].d);
            repeat (rows[i].bt * 11 + 20) @(posedge clk);
            chk(rem.got, rows[i].d);
            chk(8'(rem.low_len <= rows[i].bt), 8'h01);
            chk(8'(rem.low_len + rows[i].n + 1 > rows[i].bt), 8'h01);
            rchk(OFS_ISTAT, 8'hff, 8'h06);
            chk({7'h00, irq}, 8'h01);
            wreg(OFS_ISTAT, 8'h06);
        end
        // Abort mid-frame, then a clean frame after re-enabling.
        wreg(OFS_DATA, 8'hff);
        repeat (100) @(posedge clk);
        wreg(OFS_CTRL2, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h00, txoe}, 8'h00);
        repeat (800) @(posedge clk);
        wreg(OFS_CTRL2, 8'h80);
        wreg(OFS_DATA, 8'h81);
        repeat (64 * 11 + 20) @(posedge clk);
        chk(rem.got, 8'h81);
        // Unit off keeps the other controls and resets the flags.
        wreg(OFS_CTRL2, 8'hd5);
        wreg(OFS_CTRL1, 8'h00);
        rchk(OFS_CTRL2, 8'hff, 8'h15);
        rchk(OFS_STAT, 8'h2f, 8'h0b);
        // Receive path at sixteen clocks a bit.
        bt = 16'h10;
        wreg(OFS_CTRL1, 8'h80);
        wreg(OFS_DIV, 8'h00);
        wreg(OFS_IMASK, 8'h01);
        wreg(OFS_ISTAT, 8'h07);
        wreg(OFS_CTRL2, 8'h64);
        rem.send(9'h03c, 8);
        rchk(OFS_STAT, 8'h04, 8'h04);
        rchk(OFS_ISTAT, 8'hff, 8'h01);
        chk({6'h00, rxown, irq}, 8'h03);
        rchk(OFS_DATA, 8'hff, 8'h3c);
        wreg(OFS_ISTAT, 8'h01);
        // Address detect: a data word must vanish, an address word lands.
        wreg(OFS_CTRL2, 8'h74);
        rem.send(9'h012, 8);
        rchk(OFS_ISTAT, 8'hff, 8'h00);
        rem.send(9'h092, 8);
        rchk(OFS_ISTAT, 8'hff, 8'h01);
        rchk(OFS_DATA, 8'hff, 8'h92);
        wreg(OFS_CTRL1, 8'hc0);
        rem.send(9'h092, 9);
        rem.send(9'h112, 9);
        rchk(OFS_DATA, 8'hff, 8'h12);
        // Wake on a falling receive edge only while enabled.
        lpi <= 1'b1;
        wreg(OFS_CTRL2, 8'h64);
        rem.send(9'h000, 8);
        chk(8'(wakes), 8'h00);
        wreg(OFS_CTRL2, 8'h6c);
        rem.send(9'h000, 8);
        chk(8'(wakes), 8'h01);
        give_verdict;
    end
endmodule

bind ucb_uart_ctrl ucb_uart_ctrl_asserts #(.DIV_W(DIV_W)) u_chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_i(rx_i), .low_power_idle_i(low_power_idle_i), .tx_o(tx_o),
    .tx_oe_o(tx_oe_o), .rx_owned_o(rx_owned_o), .wake_o(wake_o),
    .irq_o(irq_o));
